// >>> iox_map.svh
/*
  Constants for the I/O and miscellaneous instruction executor:
  register offsets, field positions, reset values, opcodes, timing.
  Assumes inclusion by bare name from any file of the block.
*/
`ifndef IOX_MAP_SVH
`define IOX_MAP_SVH

// ----------------------------------------------------------
// Register offsets (4-bit register port address)
// ----------------------------------------------------------
`define IOX_ADDR_GPR_LAST 4'h3
`define IOX_ADDR_PSW      4'h4
`define IOX_ADDR_IMM      4'h5
`define IOX_ADDR_INSTR    4'h6
`define IOX_ADDR_STAT     4'h7

// ----------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------
`define IOX_PSW_CC_HI     7
`define IOX_PSW_CC_LO     6
`define IOX_PSW_IDC       5
`define IOX_PSW_CARRY     4
`define IOX_PSW_INHIBIT   3
`define IOX_STAT_BUSY     0
`define IOX_STAT_RUN      1
`define IOX_STAT_BADOP    2
`define IOX_PSW_RESET     8'h00
`define IOX_GPR_RESET     8'h00

// ----------------------------------------------------------
// Condition code values and decimal adjust constants
// ----------------------------------------------------------
`define IOX_CC_POS        2'h1
`define IOX_CC_ZERO       2'h0
`define IOX_CC_NEG        2'h2
`define IOX_CC_ALL_ONES   2'h0
`define IOX_CC_NOT_ALL    2'h2
`define IOX_DAR_C0_I0     8'hAA
`define IOX_DAR_C0_I1     8'hA0
`define IOX_DAR_C1_I1     8'h00
`define IOX_DAR_C1_I0     8'h0A

// ----------------------------------------------------------
// Opcode field (instruction bits 7:2), register field bits 1:0
// ----------------------------------------------------------
`define IOX_OPC_READ_EXT  6'h01
`define IOX_OPC_WR_DATA   6'h02
`define IOX_OPC_WR_CTRL   6'h03
`define IOX_OPC_WR_EXT    6'h04
`define IOX_OPC_NOOP      6'h05
`define IOX_OPC_MASK_TEST 6'h06
`define IOX_OPC_DEC_ADJ   6'h07
`define IOX_OPC_HALT      6'h08

// ----------------------------------------------------------
// Timing: clock periods per processor cycle and per instruction
// ----------------------------------------------------------
`define IOX_CLK_PERIOD_NS 8
`define IOX_CYCLE_CLKS    3
`define IOX_SHORT_CLKS    6
`define IOX_LONG_CLKS     9
`define IOX_SHORT_CYCLES  (`IOX_SHORT_CLKS / `IOX_CYCLE_CLKS)
`define IOX_LONG_CYCLES   (`IOX_LONG_CLKS / `IOX_CYCLE_CLKS)

`endif

// >>> iox_pkg.sv
/*
  Types for the I/O and miscellaneous instruction executor.
  Assumes no other package.
*/
`default_nettype none

package iox_pkg;

  // Executor states
  typedef enum logic [1:0] {
    IOX_IDLE = 2'b00,
    IOX_BUSY = 2'b01,
    IOX_WAIT = 2'b10
  } iox_state_t;

  // Decoded instruction kinds
  typedef enum logic [2:0] {
    IOX_OP_READ_EXT  = 3'b000,
    IOX_OP_WR_DATA   = 3'b001,
    IOX_OP_WR_CTRL   = 3'b010,
    IOX_OP_WR_EXT    = 3'b011,
    IOX_OP_NOOP      = 3'b100,
    IOX_OP_MASK_TEST = 3'b101,
    IOX_OP_DEC_ADJ   = 3'b110,
    IOX_OP_HALT      = 3'b111
  } iox_op_t;

endpackage

`default_nettype wire

// >>> iox_cycle_div.sv
/*
  Processor cycle divider: one enable pulse every three clocks.
  Assumes one clock; restart aligns a fresh cycle to the next clock.
*/
`default_nettype none
`include "iox_map.svh"

module iox_cycle_div (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic restart,
  output logic      cycle_end,
  output logic      mid_phase
);

  // ----------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------
  logic [1:0] phase;

  // Counts 0,1,2 then wraps; restart forces phase 0
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase <= 2'h0;
    end else if (restart || phase == 2'(`IOX_CYCLE_CLKS - 1)) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Last and middle clock of each processor cycle
  assign cycle_end = (phase == 2'(`IOX_CYCLE_CLKS - 1)) && !restart;
  assign mid_phase = (phase == 2'h1);

endmodule

`default_nettype wire

// >>> iox_alu.sv
/*
  Arithmetic helpers: sign condition code, masked bit test and
  decimal adjust constant addition. Purely combinational.
*/
`default_nettype none
`include "iox_map.svh"

module iox_alu (
  input  wire logic [7:0] value,
  input  wire logic [7:0] mask,
  input  wire logic [7:0] in_byte,
  input  wire logic       carry,
  input  wire logic       interdigit_carry,
  output logic      [1:0] sign_cc,
  output logic      [1:0] mask_cc,
  output logic      [7:0] adjusted
);

  // ----------------------------------------------------------
  // Condition codes
  // ----------------------------------------------------------
  // Sign class of the incoming byte
  assign sign_cc = in_byte[7] ? `IOX_CC_NEG :
                   (in_byte == 8'h00) ? `IOX_CC_ZERO : `IOX_CC_POS;   // [RQ1]

  // Only bits selected by the mask are examined
  assign mask_cc = ((value & mask) == mask) ? `IOX_CC_ALL_ONES
                                            : `IOX_CC_NOT_ALL;       // [RQ8] [RQ9]

  // ----------------------------------------------------------
  // Decimal adjust
  // ----------------------------------------------------------
  logic [7:0] dar_const;

  // Constant chosen by carry and interdigit carry
  always_comb begin
    unique case ({carry, interdigit_carry})
      2'b00:   dar_const = `IOX_DAR_C0_I0;   // [RQ10]
      2'b01:   dar_const = `IOX_DAR_C0_I1;
      2'b11:   dar_const = `IOX_DAR_C1_I1;
      2'b10:   dar_const = `IOX_DAR_C1_I0;
    endcase
  end

  assign adjusted = value + dar_const;   // Carry out dropped

endmodule

`default_nettype wire

// >>> iox_io_exec.sv
/*
  Executor for I/O and miscellaneous instructions of a byte-wide
  processor: extended input, data/control/extended output, no-op,
  masked bit test, decimal adjust and halt into the wait state.
  Assumes a register port on the same clock, an external I/O bus
  whose data and interrupt pins are asynchronous, one 125 MHz clock.
*/
// Summary of operation
// RQ1: extended input loads byte, sets sign code
// RQ2: extended input: request, address, IO, read, extended
// RQ3: bus bits are active high both ways
// RQ4: data output: two cycles, data select, pulse
// RQ5: control output: two cycles, control select, pulse
// RQ6: extended output: three cycles, address and data
// RQ7: no-op changes nothing, takes two cycles
// RQ8: mask test examines only mask-selected bits
// RQ9: all selected ones gives 00, else 10
// RQ10: decimal adjust adds constant from carry flags
// RQ11: decimal adjust keeps carry and interdigit carry
// RQ12: halt takes two cycles, enters wait state
// RQ13: wait left only by reset or interrupt
// RQ14: opcode patterns kept as replaceable constants
// RQ15: processor cycle is three clock periods
`default_nettype none
`include "iox_map.svh"

module iox_io_exec (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output var  logic [7:0] reg_rdata,
  input  wire logic [7:0] data_in,
  output var  logic [7:0] data_out,
  output logic            data_oe,
  output var  logic [7:0] address_out,
  output logic            operation_request,
  output logic            memory_select,
  output logic            write_select,
  output logic            data_select,
  output logic            extended_select,
  output logic            write_strobe_pulse,
  input  wire logic       interrupt_request,
  output var  logic       run_wait
);

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  iox_pkg::iox_state_t state;
  iox_pkg::iox_op_t    cur_op, dec_op;
  logic [7:0]          gpr [0:3];
  logic [7:0]          imm, instr, sel_reg, adjusted, psw, stat;
  logic [7:0]          data_meta, data_sync;
  logic [1:0]          cur_reg, cyc_left, cond_code, sign_cc, mask_cc;
  logic                carry, interdigit_carry, inhibit, bad_op, irq_meta, irq_sync;
  logic                dec_valid, start, cycle_end, mid_phase, last_cycle, finish;
  logic                io_op, long_op, wr_op, wake;

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  // Two flops on the data bus and interrupt pin
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_meta <= 8'h00;
      data_sync <= 8'h00;
      irq_meta  <= 1'b0;
      irq_sync  <= 1'b0;
    end else begin
      data_meta <= data_in;
      data_sync <= data_meta;
      irq_meta  <= interrupt_request;
      irq_sync  <= irq_meta;
    end
  end

  // ----------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------
  // Opcode field compared against replaceable patterns
  always_comb begin
    dec_valid = 1'b1;
    dec_op    = iox_pkg::IOX_OP_NOOP;
    unique case (reg_wdata[7:2])                       // [RQ14]
      `IOX_OPC_READ_EXT:  dec_op = iox_pkg::IOX_OP_READ_EXT;
      `IOX_OPC_WR_DATA:   dec_op = iox_pkg::IOX_OP_WR_DATA;
      `IOX_OPC_WR_CTRL:   dec_op = iox_pkg::IOX_OP_WR_CTRL;
      `IOX_OPC_WR_EXT:    dec_op = iox_pkg::IOX_OP_WR_EXT;
      `IOX_OPC_NOOP:      dec_op = iox_pkg::IOX_OP_NOOP;
      `IOX_OPC_MASK_TEST: dec_op = iox_pkg::IOX_OP_MASK_TEST;
      `IOX_OPC_DEC_ADJ:   dec_op = iox_pkg::IOX_OP_DEC_ADJ;
      `IOX_OPC_HALT:      dec_op = iox_pkg::IOX_OP_HALT;
      default:            dec_valid = 1'b0;
    endcase
  end

  // Issue only from idle with a known opcode
  assign start = reg_write && reg_addr == `IOX_ADDR_INSTR
                 && state == iox_pkg::IOX_IDLE && dec_valid;

  // ----------------------------------------------------------
  // Instruction classes
  // ----------------------------------------------------------
  assign io_op   = cur_op inside {iox_pkg::IOX_OP_READ_EXT, iox_pkg::IOX_OP_WR_DATA,
                                  iox_pkg::IOX_OP_WR_CTRL, iox_pkg::IOX_OP_WR_EXT};
  assign wr_op   = cur_op inside {iox_pkg::IOX_OP_WR_DATA, iox_pkg::IOX_OP_WR_CTRL,
                                  iox_pkg::IOX_OP_WR_EXT};
  assign long_op = dec_op inside {iox_pkg::IOX_OP_READ_EXT, iox_pkg::IOX_OP_WR_EXT,
                                  iox_pkg::IOX_OP_MASK_TEST, iox_pkg::IOX_OP_DEC_ADJ};

  // ----------------------------------------------------------
  // Cycle timing
  // ----------------------------------------------------------
  // Three clocks per processor cycle, aligned to issue
  iox_cycle_div u_div (
    .clock     (clock),
    .nrst      (nrst),
    .restart   (start),
    .cycle_end (cycle_end),
    .mid_phase (mid_phase)
  );                                                   // [RQ15]

  assign last_cycle = state == iox_pkg::IOX_BUSY && cyc_left == 2'h1;
  assign finish     = last_cycle && cycle_end;

  // Remaining processor cycles of the running instruction
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cyc_left <= 2'h0;
    end else if (start) begin
      cyc_left <= long_op ? 2'(`IOX_LONG_CYCLES)       // [RQ6] [RQ8] [RQ10]
                          : 2'(`IOX_SHORT_CYCLES);     // [RQ4] [RQ5] [RQ7] [RQ12]
    end else if (state == iox_pkg::IOX_BUSY && cycle_end) begin
      cyc_left <= cyc_left - 2'h1;
    end
  end

  // ----------------------------------------------------------
  // Instruction latch
  // ----------------------------------------------------------
  // Holds opcode, register field and instruction byte during execution
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cur_op  <= iox_pkg::IOX_OP_NOOP;
      cur_reg <= 2'h0;
      instr   <= 8'h00;
    end else if (start) begin
      cur_op  <= dec_op;
      cur_reg <= reg_wdata[1:0];
      instr   <= reg_wdata;
    end
  end

  // Immediate byte: address or mask for two-byte forms
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      imm <= 8'h00;
    end else if (reg_write && reg_addr == `IOX_ADDR_IMM
                 && state != iox_pkg::IOX_BUSY) begin
      imm <= reg_wdata;
    end
  end

  // ----------------------------------------------------------
  // Execution state
  // ----------------------------------------------------------
  assign wake = irq_sync && !inhibit;

  // Idle, busy for the instruction, or halted in wait
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= iox_pkg::IOX_IDLE;
    end else begin
      unique case (state)
        iox_pkg::IOX_IDLE: begin
          if (start) begin
            state <= iox_pkg::IOX_BUSY;
          end
        end
        iox_pkg::IOX_BUSY: begin
          if (finish) begin
            state <= (cur_op == iox_pkg::IOX_OP_HALT) ? iox_pkg::IOX_WAIT
                                                      : iox_pkg::IOX_IDLE;  // [RQ12]
          end
        end
        iox_pkg::IOX_WAIT: begin
          if (wake) begin
            state <= iox_pkg::IOX_IDLE;                // [RQ13]
          end
        end
        default: state <= iox_pkg::IOX_IDLE;
      endcase
    end
  end

  // Run level high, wait level low after a halt
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_wait <= 1'b1;
    end else if (finish && cur_op == iox_pkg::IOX_OP_HALT) begin
      run_wait <= 1'b0;                                // [RQ12]
    end else if (state == iox_pkg::IOX_WAIT && wake) begin
      run_wait <= 1'b1;                                // [RQ13]
    end
  end

  // ----------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------
  assign sel_reg = gpr[cur_reg];

  iox_alu u_alu (
    .value    (sel_reg),
    .mask     (imm),
    .in_byte  (data_sync),
    .carry    (carry),
    .interdigit_carry      (interdigit_carry),
    .sign_cc  (sign_cc),
    .mask_cc  (mask_cc),
    .adjusted (adjusted)
  );

  // ----------------------------------------------------------
  // General registers
  // ----------------------------------------------------------
  // Instruction result wins over a same-cycle software write
  for (genvar i = 0; i < 4; i++) begin : g_gpr
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        gpr[i] <= `IOX_GPR_RESET;
      end else if (finish && cur_reg == 2'(i)
                   && cur_op == iox_pkg::IOX_OP_READ_EXT) begin
        gpr[i] <= data_sync;                           // [RQ1] [RQ3]
      end else if (finish && cur_reg == 2'(i)
                   && cur_op == iox_pkg::IOX_OP_DEC_ADJ) begin
        gpr[i] <= adjusted;                            // [RQ10]
      end else if (reg_write && reg_addr == 4'(i)
                   && state != iox_pkg::IOX_BUSY) begin
        gpr[i] <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------
  // Program status
  // ----------------------------------------------------------
  // Condition code: sign on input, mask result on test
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cond_code <= 2'(`IOX_PSW_RESET >> `IOX_PSW_CC_LO);
    end else if (finish && cur_op == iox_pkg::IOX_OP_READ_EXT) begin
      cond_code <= sign_cc;                            // [RQ1]
    end else if (finish && cur_op == iox_pkg::IOX_OP_MASK_TEST) begin
      cond_code <= mask_cc;                            // [RQ9]
    end else if (reg_write && reg_addr == `IOX_ADDR_PSW
                 && state != iox_pkg::IOX_BUSY) begin
      cond_code <= reg_wdata[`IOX_PSW_CC_HI:`IOX_PSW_CC_LO];
    end
  end

  // Carry flags: written by software only, never by adjust
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      carry <= 1'b0;
      interdigit_carry   <= 1'b0;
    end else if (reg_write && reg_addr == `IOX_ADDR_PSW
                 && state != iox_pkg::IOX_BUSY) begin
      carry <= reg_wdata[`IOX_PSW_CARRY];               // [RQ11]
      interdigit_carry   <= reg_wdata[`IOX_PSW_IDC];
    end
  end

  // Interrupt inhibit: set when an interrupt wakes the core
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      inhibit <= 1'b0;
    end else if (state == iox_pkg::IOX_WAIT && wake) begin
      inhibit <= 1'b1;
    end else if (reg_write && reg_addr == `IOX_ADDR_PSW) begin
      inhibit <= reg_wdata[`IOX_PSW_INHIBIT];
    end
  end

  // Unknown opcode flag; a new event beats the clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bad_op <= 1'b0;
    end else if (reg_write && reg_addr == `IOX_ADDR_INSTR && !dec_valid) begin
      bad_op <= 1'b1;
    end else if (reg_write && reg_addr == `IOX_ADDR_STAT
                 && reg_wdata[`IOX_STAT_BADOP]) begin
      bad_op <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // External bus
  // ----------------------------------------------------------
  // Data and address latched entering the final cycle (short forms also at issue), held through it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_out    <= 8'h00;
      address_out <= 8'h00;
    end else if (state == iox_pkg::IOX_BUSY && cyc_left == 2'h2
                 && cycle_end) begin
      data_out    <= sel_reg;                          // [RQ4] [RQ5] [RQ6] [RQ3]
      address_out <= (cur_op inside {iox_pkg::IOX_OP_READ_EXT, iox_pkg::IOX_OP_WR_EXT})
                     ? imm : 8'h00;                    // [RQ2] [RQ6]
    end else if (start && !long_op) begin
      data_out    <= gpr[reg_wdata[1:0]];
      address_out <= 8'h00;
    end
  end

  // Request asserted through the final processor cycle
  assign operation_request  = last_cycle && io_op;                    // [RQ2] [RQ4] [RQ5] [RQ6]
  assign memory_select      = 1'b0;                                   // [RQ2]
  assign write_select       = last_cycle && wr_op;                    // [RQ4] [RQ5] [RQ6]
  assign data_select        = last_cycle && cur_op == iox_pkg::IOX_OP_WR_DATA;  // [RQ4] [RQ5]
  assign extended_select    = last_cycle && (cur_op == iox_pkg::IOX_OP_READ_EXT
                                             || cur_op == iox_pkg::IOX_OP_WR_EXT); // [RQ2] [RQ6]
  assign write_strobe_pulse = last_cycle && wr_op && mid_phase;       // [RQ4] [RQ5] [RQ6]
  assign data_oe            = last_cycle && wr_op;

  // ----------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------
  assign psw  = {cond_code, interdigit_carry, carry, inhibit, 3'h0};
  assign stat = {5'h00, bad_op, run_wait, state == iox_pkg::IOX_BUSY};

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (reg_addr <= `IOX_ADDR_GPR_LAST) begin
        reg_rdata <= gpr[reg_addr[1:0]];
      end else if (reg_addr == `IOX_ADDR_PSW) begin
        reg_rdata <= psw;
      end else if (reg_addr == `IOX_ADDR_IMM) begin
        reg_rdata <= imm;
      end else if (reg_addr == `IOX_ADDR_INSTR) begin
        reg_rdata <= instr;
      end else if (reg_addr == `IOX_ADDR_STAT) begin
        reg_rdata <= stat;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// >>> iox_io_exec_monitor.sv
/* Bus timing checker for the I/O executor.
   Assumes binding to the ports of iox_io_exec. */
`default_nettype none
`include "iox_map.svh"
module iox_io_exec_monitor (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic [7:0] address_out,
  input wire logic       operation_request,
  input wire logic       memory_select,
  input wire logic       write_select,
  input wire logic       data_select,
  input wire logic       extended_select,
  input wire logic       write_strobe_pulse,
  input wire logic       interrupt_request,
  input wire logic       run_wait
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic go_data;
  // Data output instruction issued
  assign go_data = reg_write && reg_addr == `IOX_ADDR_INSTR && reg_wdata[7:2] == `IOX_OPC_WR_DATA;
  a_data_start_time: assert property (go_data |=> !operation_request[*3] ##1
    (operation_request && data_select && write_select)[*3] ##1 !operation_request) else $error("data output timing");
  a_request_len: assert property ($rose(operation_request) |-> operation_request[*3] ##1 !operation_request)
    else $error("request length");
  a_pulse_mid: assert property ($rose(operation_request) && write_select |=> write_strobe_pulse ##1 !write_strobe_pulse)
    else $error("write pulse place");
  a_pulse_qual: assert property (write_strobe_pulse |-> operation_request && write_select && data_oe)
    else $error("write pulse unqualified");
  a_io_space: assert property (operation_request |-> !memory_select) else $error("memory space selected");
  a_read_ext: assert property (operation_request && !write_select |-> extended_select && !data_oe)
    else $error("read not extended");
  a_data_only: assert property (data_select |-> operation_request && write_select && !extended_select)
    else $error("data select misplaced");
  a_bus_hold: assert property (operation_request && !$rose(operation_request) |-> $stable(data_out)
    && $stable(address_out)) else $error("bus moved in request");
  a_wait_hold: assert property ((!interrupt_request)[*5] ##0 !run_wait |=> !run_wait)
    else $error("left wait without cause");
endmodule
bind iox_io_exec iox_io_exec_monitor iox_io_exec_monitor_i (.clock, .nrst, .reg_addr, .reg_wdata, .reg_write,
  .data_out, .data_oe, .address_out, .operation_request, .memory_select, .write_select, .data_select,
  .extended_select, .write_strobe_pulse, .interrupt_request, .run_wait);
`default_nettype wire

// >>> iox_io_dev.sv
/* External I/O device on the processor bus.
   Assumes the executor's bus outputs; answers reads at once. */
`default_nettype none
module iox_io_dev (
  input  wire logic       clock,
  input  wire logic       operation_request,
  input  wire logic       write_select,
  input  wire logic       data_select,
  input  wire logic       extended_select,
  input  wire logic       write_strobe_pulse,
  input  wire logic [7:0] address_out,
  input  wire logic [7:0] data_out,
  output logic      [7:0] data_in,
  output logic      [7:0] got_addr,
  output logic      [7:0] got_data,
  output logic      [1:0] got_kind,
  output logic      [7:0] got_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last = 8'h00;
  // Port address returned on extended read, moving pattern when idle
  always_comb data_in = (operation_request && !write_select && extended_select) ? address_out : ~last;
  always @(posedge clock) last <= data_in;
  // Capture each write, kind as extended and data select bits
  initial got_count = 8'h00;
  always @(posedge clock) begin
    if (write_strobe_pulse) begin
      got_addr  <= address_out;
      got_data  <= data_out;
      got_kind  <= {extended_select, data_select};
      got_count <= got_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> iox_io_exec_test.sv
/* Self-checking bench of the I/O executor.
   Assumes the device model iox_io_dev and the bound checker. */
`default_nettype none
`include "iox_map.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module iox_io_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock, nrst, reg_write, reg_read, interrupt_request, data_oe, operation_request;
  logic       memory_select, write_select, data_select, extended_select, write_strobe_pulse, run_wait;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, data_in, data_out, address_out, got_addr, got_data, got_count, v;
  logic [1:0] got_kind;
  int         err_total = 0;
  int         cmp_count = 0;
  iox_io_exec iox_io_exec_i (.clock, .nrst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .data_in, .data_out, .data_oe, .address_out, .operation_request, .memory_select, .write_select,
    .data_select, .extended_select, .write_strobe_pulse, .interrupt_request, .run_wait);
  iox_io_dev iox_io_dev_i (.clock, .operation_request, .write_select, .data_select, .extended_select,
    .write_strobe_pulse, .address_out, .data_out, .data_in, .got_addr, .got_data, .got_kind, .got_count);
  // Clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Start an instruction, check busy at its last clock and idle after
  task automatic ex(input logic [5:0] op, input logic [1:0] r, input int n);
    wr(`IOX_ADDR_INSTR, {op, r});
    repeat (n - 2) @(posedge clock);
    rd(`IOX_ADDR_STAT, v);
    `CHK(v[`IOX_STAT_BUSY], 1'b1)
    rd(`IOX_ADDR_STAT, v);
    `CHK(v[`IOX_STAT_BUSY], 1'b0)
  endtask
  task automatic t_out;
    wr(4'h1, 8'hC3);
    ex(`IOX_OPC_WR_DATA, 2'h1, 6);
    `CHK({got_kind, got_data}, 10'h1C3)
    wr(4'h2, 8'h3C);
    ex(`IOX_OPC_WR_CTRL, 2'h2, 6);
    `CHK({got_kind, got_data}, 10'h03C)
    wr(`IOX_ADDR_IMM, 8'h96);
    wr(4'h3, 8'h5E);
    ex(`IOX_OPC_WR_EXT, 2'h3, 9);
    `CHK({got_kind, got_addr, got_data, got_count}, 26'h2965E03)
  endtask
  task automatic t_read;
    logic [7:0] rv [3] = '{8'h25, 8'h00, 8'hF0};
    logic [1:0] rc [3] = '{`IOX_CC_POS, `IOX_CC_ZERO, `IOX_CC_NEG};
    for (int i = 0; i < 3; i++) begin
      wr(`IOX_ADDR_IMM, rv[i]);
      ex(`IOX_OPC_READ_EXT, 2'h2, 9);
      rd(4'h2, v);
      `CHK(v, rv[i])
      rd(`IOX_ADDR_PSW, v);
      `CHK(v[7:6], rc[i])
    end
  endtask
  task automatic t_noop;
    wr(`IOX_ADDR_PSW, 8'h40);
    wr(4'h0, 8'h7E);
    ex(`IOX_OPC_NOOP, 2'h0, 6);
    rd(4'h0, v);
    `CHK(v, 8'h7E)
    rd(`IOX_ADDR_PSW, v);
    `CHK(v, 8'h40)
  endtask
  task automatic t_mask;
    logic [7:0] mk [4] = '{8'h35, 8'h4A, 8'h00, 8'hFF};
    logic [1:0] mc [4] = '{`IOX_CC_ALL_ONES, `IOX_CC_NOT_ALL, `IOX_CC_ALL_ONES, `IOX_CC_NOT_ALL};
    wr(4'h1, 8'hB5);
    for (int i = 0; i < 4; i++) begin
      wr(`IOX_ADDR_IMM, mk[i]);
      ex(`IOX_OPC_MASK_TEST, 2'h1, 9);
      rd(`IOX_ADDR_PSW, v);
      `CHK(v[7:6], mc[i])
      rd(4'h1, v);
      `CHK(v, 8'hB5)
    end
  endtask
  task automatic t_adjust;
    logic [1:0] cf [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    logic [7:0] k [4] = '{`IOX_DAR_C0_I0, `IOX_DAR_C0_I1, `IOX_DAR_C1_I1, `IOX_DAR_C1_I0};
    for (int i = 0; i < 4; i++) begin
      wr(`IOX_ADDR_PSW, {2'b00, cf[i][0], cf[i][1], 4'h0});
      wr(4'h3, 8'h11);
      ex(`IOX_OPC_DEC_ADJ, 2'h3, 9);
      rd(4'h3, v);
      `CHK(v, 8'h11 + k[i])
      rd(`IOX_ADDR_PSW, v);
      `CHK(v[5:4], {cf[i][0], cf[i][1]})
    end
  endtask
  task automatic t_halt;
    wr(`IOX_ADDR_PSW, 8'h00);
    ex(`IOX_OPC_HALT, 2'h0, 6);
    `CHK(run_wait, 1'b0)
    wr(`IOX_ADDR_INSTR, {`IOX_OPC_NOOP, 2'h0});
    repeat (8) @(posedge clock);
    `CHK(run_wait, 1'b0)
    interrupt_request <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK(run_wait, 1'b1)
    interrupt_request <= 1'b0;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence after two reset cycles
  initial begin
    {nrst, reg_write, reg_read, interrupt_request, reg_addr, reg_wdata} = '0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    #1 `CHK(run_wait, 1'b1)
    rd(4'hA, v);
    `CHK(v, 8'h00)
    wr(`IOX_ADDR_INSTR, 8'hFC);
    rd(`IOX_ADDR_STAT, v);
    `CHK(v, 8'h06)
    t_out();
    t_read();
    t_noop();
    t_mask();
    t_adjust();
    t_halt();
    conclude();
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    conclude();
  end
endmodule
`undef CHK
`default_nettype wire
